/* sfm_fault_monitor.sv */
// Fault monitor of a five-channel high-side switch with Avalon-MM registers
// How it works
// - Filtered undervoltage sets summary and supply-low
// - Normal mode: undervoltage restart needs host ON write
// - Supply flags clear after condition gone plus read
// - Fail mode restarts undervoltage-off outputs automatically
// - Auto-restart interval is 64 ms
// - Overvoltage sets summary and supply-high flags
// - Supply filters need 3.5 us persistence
// - Before pump settles, outputs off, commands held
// - Filtered pump fault disables outputs, sets flags
// - Held command executes when pump valid again
// - Pump flag clears after recovery plus read
// - Pump filter needs 4.0 us persistence
// - Open-load detection per channel while on
// - LED select bit picks detection threshold
// - Open load sets quick, global, channel flags
// - Channel open-load flag clears after recovery, read
// - Open load never switches the output off
// - Filter-select bit picks 64 us or 2 ms
// - Open-load filter resets when output goes low
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module sfm_fault_monitor #(
	parameter int NUM_CH = sfm_pkg::NUM_CH,
	parameter int RESTART_CYC = sfm_pkg::RESTART_CYC,
	parameter int OL_CONV_CYC = sfm_pkg::OL_CONV_FILTER_CYC,
	parameter int OL_BULB_CYC = sfm_pkg::OL_BULB_FILTER_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Analog comparators
	input wire sfm_pkg::sfm_supply_s supplyCmp,
	input wire sfm_pkg::sfm_olcmp_s [NUM_CH-1:0] olCmp,
	// Power stage enables
	output logic [NUM_CH-1:0] outEnable
);

	localparam int CW = 24;

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ACK
	} sfm_bus_e;

	typedef struct packed {
		sfm_bus_e bus;
		logic [31:0] readdata;
		logic [NUM_CH-1:0] onCmd;
		logic [NUM_CH-1:0] uvOff;
		logic [NUM_CH-1:0] outOn;
		logic [NUM_CH-1:0] filtSel;
		logic [NUM_CH-1:0] ledSel;
		logic [NUM_CH-1:0] olFlag;
		logic [2:0] chSel;
		logic failMode;
		logic supplyLowFlag;
		logic supplyHighFlag;
		logic pumpFaultFlag;
		logic [CW-1:0] restartCnt;
	} sfm_state_s;

	sfm_state_s state;
	sfm_state_s next_state;

	logic uvSeen;
	logic ovSeen;
	logic cpSeen;
	logic [NUM_CH-1:0] olSeen;
	logic [NUM_CH-1:0] olRaw;
	logic deviceFaultSummary;
	logic globalOpenloadFlag;
	logic [NUM_CH-1:0] channelQuickFault;
	logic outputsBlocked;

	// Word of every mapped register, used only by the read path
	function automatic logic [31:0] sfm_read_word(input sfm_state_s s, input logic device_fault_summary_flag,
		input logic global_openload_flag, input logic [NUM_CH-1:0] qsf);
		logic [31:0] w;
		w = 32'h00000000;
		unique case (s.bus == BUS_IDLE ? address : 4'hf)
			sfm_pkg::ADDR_STATUS:
				w = {24'h000000, device_fault_summary_flag, global_openload_flag, s.pumpFaultFlag, qsf};
			sfm_pkg::ADDR_CH_STATUS:
				w = {30'h00000000, device_fault_summary_flag, s.olFlag[s.chSel]};
			sfm_pkg::ADDR_DEV_STATUS:
				w = {29'h00000000, device_fault_summary_flag, s.supplyHighFlag, s.supplyLowFlag};
			sfm_pkg::ADDR_OUT_CTRL:
				w = {27'h0000000, s.onCmd};
			sfm_pkg::ADDR_OL_CTRL:
				w = {19'h00000, s.ledSel, 3'h0, s.filtSel};
			sfm_pkg::ADDR_MODE:
				w = {31'h00000000, s.failMode};
			sfm_pkg::ADDR_CH_SEL:
				w = {29'h00000000, s.chSel};
			default:
				w = sfm_pkg::UNMAPPED_DATA;
		endcase
		return w;
	endfunction : sfm_read_word

	// --------------------------------------------------------------
	// Filters
	// --------------------------------------------------------------
	// supply and pump persistence filters
	sfm_filter #(.WIDTH(CW)) uvFilt (
		.clk(clk),
		.rst_b(rst_b),
		.condIn(supplyCmp.supplyLow),
		.limit(CW'(sfm_pkg::SUPPLY_FILTER_CYC)),
		.accepted(uvSeen)
	);

	sfm_filter #(.WIDTH(CW)) ovFilt (
		.clk(clk),
		.rst_b(rst_b),
		.condIn(supplyCmp.supplyHigh),
		.limit(CW'(sfm_pkg::SUPPLY_FILTER_CYC)),
		.accepted(ovSeen)
	);

	sfm_filter #(.WIDTH(CW)) cpFilt (
		.clk(clk),
		.rst_b(rst_b),
		.condIn(supplyCmp.pumpBad),
		.limit(CW'(sfm_pkg::PUMP_FILTER_CYC)),
		.accepted(cpSeen)
	);

	// One open-load filter per channel, counting only while that output is high
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : gOl
			assign olRaw[g] = state.outOn[g] &
				(state.ledSel[g] ? olCmp[g].openloadLed : olCmp[g].openloadStd);
			// filter time by select, reset when off
			sfm_filter #(.WIDTH(CW)) olFilt (
				.clk(clk),
				.rst_b(rst_b),
				.condIn(olRaw[g]),
				.limit(state.filtSel[g] ? CW'(OL_CONV_CYC) : CW'(OL_BULB_CYC)),
				.accepted(olSeen[g])
			);
		end
	endgenerate

	// --------------------------------------------------------------
	// Summaries
	// --------------------------------------------------------------
	// summary covers supply and pump flags
	assign deviceFaultSummary = state.supplyLowFlag | state.supplyHighFlag | state.pumpFaultFlag;
	// global and quick flags from channel flags
	assign globalOpenloadFlag = |state.olFlag;
	assign channelQuickFault = state.olFlag;
	// outputs blocked until pump settles and while pump fault persists
	assign outputsBlocked = !supplyCmp.pumpSettled | cpSeen;

	// --------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------
	always_comb
	begin
		logic doWrite;
		logic doRead;
		logic [31:0] wd;
		doWrite = 1'b0;
		doRead = 1'b0;
		wd = writedata;
		next_state = state;
		// Slave answers one cycle after the request, holding waitrequest meanwhile
		next_state.bus = BUS_IDLE;
		if ((read | write) && state.bus == BUS_IDLE)
		begin
			next_state.bus = BUS_ACK;
			next_state.readdata = sfm_read_word(state, deviceFaultSummary,
				globalOpenloadFlag, channelQuickFault);
			doRead = read;
			doWrite = write & byteenable[0];
		end

		// Register writes
		if (doWrite)
		begin
			unique case (address)
				sfm_pkg::ADDR_OUT_CTRL:
				begin
					// host ON write restarts undervoltage-off channels
					next_state.onCmd = wd[NUM_CH-1:0];
					next_state.uvOff = state.uvOff & ~wd[NUM_CH-1:0];
				end
				sfm_pkg::ADDR_OL_CTRL:
				begin
					next_state.filtSel = wd[NUM_CH-1:0];
					next_state.ledSel = byteenable[1] ? wd[8+NUM_CH-1:8] : state.ledSel;
				end
				sfm_pkg::ADDR_MODE:
					next_state.failMode = wd[0];
				sfm_pkg::ADDR_CH_SEL:
					next_state.chSel = (wd[2:0] < 3'(NUM_CH)) ? wd[2:0] : state.chSel;
				default:
				begin
				end
			endcase
		end

		// supply flags clear on read only once condition gone
		if (doRead && address == sfm_pkg::ADDR_DEV_STATUS)
		begin
			if (!uvSeen)
				next_state.supplyLowFlag = 1'b0;
			if (!ovSeen)
				next_state.supplyHighFlag = 1'b0;
		end
		// pump flag clears after recovery plus read
		if (doRead && address == sfm_pkg::ADDR_STATUS && !cpSeen)
			next_state.pumpFaultFlag = 1'b0;
		// channel flag clears after recovery plus read
		if (doRead && address == sfm_pkg::ADDR_CH_STATUS && !olSeen[state.chSel])
			next_state.olFlag[state.chSel] = 1'b0;

		// Sets win over clears
		// supply, pump and channel open-load flags
		if (uvSeen)
			next_state.supplyLowFlag = 1'b1;
		if (ovSeen)
			next_state.supplyHighFlag = 1'b1;
		if (cpSeen)
			next_state.pumpFaultFlag = 1'b1;
		next_state.olFlag = next_state.olFlag | olSeen;

		if (uvSeen)
		begin
			next_state.uvOff = next_state.uvOff | next_state.onCmd;
			next_state.restartCnt = '0;
		end
		else if (state.failMode && |state.uvOff)
		begin
			if (state.restartCnt >= CW'(RESTART_CYC - 1))
			begin
				next_state.uvOff = '0;
				next_state.restartCnt = '0;
			end
			else
				next_state.restartCnt = state.restartCnt + CW'(1);
		end
		else
			next_state.restartCnt = '0;

		// held command executes once pump valid; open load ignored
		next_state.outOn = outputsBlocked ? '0 : (next_state.onCmd & ~next_state.uvOff);
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= '0;
			state.onCmd <= sfm_pkg::OUT_CTRL_RST;
			state.filtSel <= sfm_pkg::OL_FILT_RST;
			state.ledSel <= sfm_pkg::LED_SEL_RST;
		end
		else
			state <= next_state;
	end

	// Outputs
	assign waitrequest = (read | write) & (state.bus == BUS_IDLE);
	assign readdata = state.readdata;
	assign outEnable = state.outOn;

endmodule : sfm_fault_monitor

/* sfm_fault_monitor_asserts.sv */
// Port-level assertions for the fault monitor
`timescale 1ns/100ps
module sfm_fault_monitor_asserts #(
	parameter int NUM_CH = 5,
	parameter int RESTART_CYC = 200,
	parameter int OL_CONV_CYC = 100,
	parameter int OL_BULB_CYC = 20
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire sfm_pkg::sfm_supply_s supplyCmp,
	input wire sfm_pkg::sfm_olcmp_s [NUM_CH-1:0] olCmp,
	input wire logic [NUM_CH-1:0] outEnable
);
	// --------------------------------------------------------------
	// Persistence counters
	// --------------------------------------------------------------
	logic [31:0] uvCnt, hiCnt, pumpCnt, okCnt;
	// Cycles each condition has lasted; okCnt counts quiet cycles since a write or unsettled pump
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			uvCnt <= '0;
			hiCnt <= '0;
			pumpCnt <= '0;
			okCnt <= '0;
		end
		else
		begin
			uvCnt <= supplyCmp.supplyLow ? uvCnt + 32'h1 : 32'h0;
			hiCnt <= supplyCmp.supplyHigh ? hiCnt + 32'h1 : 32'h0;
			pumpCnt <= supplyCmp.pumpBad ? pumpCnt + 32'h1 : 32'h0;
			okCnt <= (write || !supplyCmp.pumpSettled) ? 32'h0 : okCnt + 32'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	a_pump_cuts: assert property (pumpCnt >= 505 |-> outEnable == '0)
		else $error("outputs on after pump fault filter");
	a_uv_cuts: assert property (uvCnt >= 442 && okCnt >= 3 |-> outEnable == '0)
		else $error("outputs on after undervoltage filter");
	a_unsettled_off: assert property ((!supplyCmp.pumpSettled) [*3] |-> outEnable == '0)
		else $error("outputs on before pump settled");
	a_fall_cause: assert property (|($past(outEnable) & ~outEnable)
		|-> okCnt < 3 || uvCnt >= 250 || pumpCnt >= 250)
		else $error("output fell without a shutdown cause");
	a_uv_flag: assert property (uvCnt >= 442 && read && !waitrequest
		&& address == sfm_pkg::ADDR_DEV_STATUS |-> readdata[0] && readdata[2])
		else $error("supply low flag missing");
	a_ov_flag: assert property (hiCnt >= 442 && read && !waitrequest
		&& address == sfm_pkg::ADDR_DEV_STATUS |-> readdata[1] && readdata[2])
		else $error("supply high flag missing");
	a_pump_flag: assert property (pumpCnt >= 505 && read && !waitrequest
		&& address == sfm_pkg::ADDR_STATUS |-> readdata[5] && readdata[7])
		else $error("pump fault flag missing");
	a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("access not answered after one wait state");
	// Main scenarios reached
	c_pump_cut: cover property (pumpCnt == 505);
	c_uv_read: cover property (uvCnt >= 442 && read && !waitrequest);
	c_ch_flag: cover property (read && !waitrequest && address == sfm_pkg::ADDR_CH_STATUS
		&& readdata[0]);
endmodule : sfm_fault_monitor_asserts

bind sfm_fault_monitor sfm_fault_monitor_asserts #(.NUM_CH(NUM_CH), .RESTART_CYC(RESTART_CYC),
	.OL_CONV_CYC(OL_CONV_CYC), .OL_BULB_CYC(OL_BULB_CYC)) u_chk (.clk(clk), .rst_b(rst_b),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
	.supplyCmp(supplyCmp), .olCmp(olCmp), .outEnable(outEnable));

/* sfm_filter.sv */
// Persistence filter: output rises after input held high for a count
`timescale 1ns/100ps
module sfm_filter #(
	parameter int WIDTH = 20
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic condIn,
	input wire logic [WIDTH-1:0] limit,
	output logic accepted
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic accepted;
	} sfm_filt_state_s;

	sfm_filt_state_s state;
	sfm_filt_state_s next_state;

	// Count while held, restart on any drop so glitches never accumulate
	always_comb
	begin
		next_state = state;
		if (!condIn)
		begin
			next_state.count = '0;
			next_state.accepted = 1'b0;
		end
		else if (state.count >= limit - WIDTH'(1))
			next_state.accepted = 1'b1;
		else
			next_state.count = state.count + WIDTH'(1);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state <= '0;
		else
			state <= next_state;
	end

	assign accepted = state.accepted;

endmodule : sfm_filter

/* sfm_pkg.sv */
// Package of constants and carrier types for the supply, pump and open-load fault monitor
package sfm_pkg;

	// --------------------------------------------------------------
	// Clock and timing
	// --------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam real SUPPLY_FILTER_US = 3.5;
	localparam real PUMP_FILTER_US = 4.0;
	localparam real OL_BULB_FILTER_US = 64.0;
	localparam real OL_CONV_FILTER_MS = 2.0;
	localparam real RESTART_MS = 64.0;
	localparam int SUPPLY_FILTER_CYC = int'(SUPPLY_FILTER_US * CLK_MHZ);
	localparam int PUMP_FILTER_CYC = int'(PUMP_FILTER_US * CLK_MHZ);
	localparam int OL_BULB_FILTER_CYC = int'(OL_BULB_FILTER_US * CLK_MHZ);
	localparam int OL_CONV_FILTER_CYC = int'(OL_CONV_FILTER_MS * 1000.0 * CLK_MHZ);
	localparam int RESTART_CYC = int'(RESTART_MS * 1000.0 * CLK_MHZ);
	localparam int NUM_CH = 5;

	// --------------------------------------------------------------
	// Register map (word offsets are byte addresses / 4)
	// --------------------------------------------------------------
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_CH_STATUS = 4'h1;
	localparam logic [3:0] ADDR_DEV_STATUS = 4'h2;
	localparam logic [3:0] ADDR_OUT_CTRL = 4'h3;
	localparam logic [3:0] ADDR_OL_CTRL = 4'h4;
	localparam logic [3:0] ADDR_MODE = 4'h5;
	localparam logic [3:0] ADDR_CH_SEL = 4'h6;
	localparam logic [4:0] OUT_CTRL_RST = 5'h00;
	localparam logic [4:0] OL_FILT_RST = 5'h00;
	localparam logic [4:0] LED_SEL_RST = 5'h00;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

	// Per-channel analog comparator inputs
	typedef struct packed {
		logic openloadStd;
		logic openloadLed;
	} sfm_olcmp_s;

	// Analog supply comparator inputs
	typedef struct packed {
		logic supplyLow;
		logic supplyHigh;
		logic pumpBad;
		logic pumpSettled;
	} sfm_supply_s;

endpackage : sfm_pkg

/* sfm_plant.sv */
// Load-side model: open-load comparators seen by the fault monitor
`timescale 1ns/100ps
module sfm_plant #(
	parameter int NUM_CH = 5
) (
	input wire logic clk,
	input wire logic [NUM_CH-1:0] olStd,
	input wire logic [NUM_CH-1:0] olLed,
	output sfm_pkg::sfm_olcmp_s [NUM_CH-1:0] olCmp
);
	// --------------------------------------------------------------
	// Comparators
	// --------------------------------------------------------------
	// Registered so that a level set by the bench lands one cycle later, like a real comparator
	// The level is not gated by the output, so the monitor itself must ignore an off channel
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			olCmp[i].openloadStd <= olStd[i];
			olCmp[i].openloadLed <= olLed[i];
		end
	end
endmodule : sfm_plant

/* tb_sfm_fault_monitor.sv */
// Self-checking testbench of the fault monitor
`timescale 1ns/100ps
module tb_sfm_fault_monitor;
	localparam logic [3:0] STAT = sfm_pkg::ADDR_STATUS;
	localparam logic [3:0] CHS = sfm_pkg::ADDR_CH_STATUS;
	localparam logic [3:0] DEV = sfm_pkg::ADDR_DEV_STATUS;
	localparam logic [3:0] OUTC = sfm_pkg::ADDR_OUT_CTRL;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] readdata, rdData;
	logic waitrequest;
	sfm_pkg::sfm_supply_s supplyCmp = 4'h0;
	sfm_pkg::sfm_olcmp_s [4:0] olCmp;
	logic [4:0] outEnable;
	logic [4:0] olStd = 5'h00;
	logic [4:0] olLed = 5'h00;
	int fails = 0;
	int compares = 0;
	always #4 clk = ~clk;
	sfm_fault_monitor #(.RESTART_CYC(200), .OL_CONV_CYC(100), .OL_BULB_CYC(20)) u_dut (
		.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .supplyCmp(supplyCmp), .olCmp(olCmp), .outEnable(outEnable));
	sfm_plant #(.NUM_CH(5)) u_plant (.clk(clk), .olStd(olStd), .olLed(olLed), .olCmp(olCmp));
	// --------------------------------------------------------------
	// Bus and check tasks
	// --------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic end_of_test();
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Holds the request until waitrequest is sampled low, then idles one edge
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] be);
		address <= a;
		read <= !w;
		write <= w;
		writedata <= d;
		byteenable <= be;
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		rdData = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		bus(a, 1'b1, d, be);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
		bus(a, 1'b0, 32'h0, 4'h0);
		chk(rdData & m, exp);
	endtask : rd
	task automatic oe(input logic [4:0] exp);
		chk(32'(outEnable), 32'(exp));
	endtask : oe
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	// Run is about 2500 cycles, so the watchdog allows eight times that
	initial
	begin
		#(8 * 20000);
		fails++;
		end_of_test();
	end
	initial
	begin
		cyc(16);
		rst_b <= 1'b1;
		cyc(2);
		wr(OUTC, 32'h1f, 4'h1);
		cyc(5);
		oe(5'h00);
		supplyCmp.pumpSettled <= 1'b1;
		cyc(4);
		oe(5'h1f);
		rd(4'hf, 32'h0, 32'hffffffff);
		// Channel 1 converter filter, channel 2 watches the LED comparator
		wr(sfm_pkg::ADDR_OL_CTRL, 32'h0402, 4'h3);
		olStd <= 5'h07;
		cyc(10);
		rd(STAT, 32'h00, 32'h7f);
		cyc(15);
		rd(STAT, 32'h41, 32'h7f);
		oe(5'h1f);
		wr(OUTC, 32'h1d, 4'h1);
		wr(OUTC, 32'h1f, 4'h1);
		cyc(80);
		rd(STAT, 32'h41, 32'h7f);
		cyc(25);
		rd(STAT, 32'h43, 32'h7f);
		olLed <= 5'h04;
		cyc(25);
		rd(STAT, 32'h47, 32'h7f);
		wr(sfm_pkg::ADDR_CH_SEL, 32'h0, 4'h1);
		rd(CHS, 32'h1, 32'h1);
		olStd <= 5'h00;
		olLed <= 5'h00;
		cyc(3);
		rd(CHS, 32'h1, 32'h1);
		rd(CHS, 32'h0, 32'h1);
		// Undervoltage then overvoltage: flag, held while present, cleared after
		for (int k = 0; k < 2; k++)
		begin
			supplyCmp <= k ? 4'h5 : 4'h9;
			cyc(450);
			rd(DEV, k ? 32'h6 : 32'h5, 32'h7);
			supplyCmp <= 4'h1;
			cyc(5);
			if (k == 0)
				oe(5'h00);
			rd(DEV, k ? 32'h2 : 32'h1, 32'h3);
			rd(DEV, 32'h0, 32'h3);
		end
		wr(OUTC, 32'h1f, 4'h1);
		cyc(3);
		oe(5'h1f);
		supplyCmp <= 4'h3;
		cyc(510);
		oe(5'h00);
		wr(OUTC, 32'h03, 4'h1);
		rd(STAT, 32'ha0, 32'ha0);
		supplyCmp <= 4'h1;
		cyc(4);
		oe(5'h03);
		wr(OUTC, 32'h00, 4'he);
		oe(5'h03);
		rd(STAT, 32'h20, 32'h20);
		rd(STAT, 32'h00, 32'h20);
		// Fail mode: restart without a host write
		wr(sfm_pkg::ADDR_MODE, 32'h1, 4'h1);
		supplyCmp <= 4'h9;
		cyc(450);
		supplyCmp <= 4'h1;
		cyc(190);
		oe(5'h00);
		cyc(20);
		oe(5'h03);
		end_of_test();
	end
endmodule : tb_sfm_fault_monitor
